// ==== rtl/plsram_pkg.sv ====
package plsram_pkg;
	localparam int unsigned LANE_W = 9;
	localparam int unsigned LANES = 8;
	localparam int unsigned DATA_W = LANE_W * LANES;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned BURST_W = 2;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned PIPE_LAT = 2;
	localparam int unsigned FLOW_LAT = 1;
	localparam logic [1:0] CNT_STEP = 2'h1;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] RST_SYNC_ONES = 2'h3;
	localparam logic [1:0] PIPE_STAGES_ZERO = 2'h0;
endpackage : plsram_pkg

// ==== rtl/plsram_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module plsram_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o = mem_ff[rd_ptr_ff];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop) rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk_i) begin
		if (push) mem_ff[wr_ptr_ff] <= in_data_i;
	end
endmodule : plsram_fifo
`default_nettype wire

// ==== rtl/plsram_core.sv ====
// Function
// - inputs other than the asynchronous reset rstn_i sampled only on rising clock edge
// - output enable off turns drivers off synchronously, three edges later
// - sleep request forces power-down state
// - writes start on edge, self-timed internally
// - static select picks pipelined or flow-through
// - pipelined read held in output register
// - read and write follow back to back
// - double late write pipelined, single flow-through
// - nine-bit lanes with own write enables
// - selected only when three chip selects active
// - clock gate high suspends all but the oe and sleep paths, holds state
// - write with no lane enabled changes nothing
`timescale 1ns/1ns
`default_nettype none
module plsram_core
	import plsram_pkg::*;
#(
	parameter int unsigned A_W = ADDR_W
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clock_gate_n_i,
	input wire logic [A_W-1:0] addr_i,
	input wire logic advance_load_i,
	input wire logic write_n_i,
	input wire logic [LANES-1:0] byte_lane_write_n_i,
	input wire logic chip_select_first_n_i,
	input wire logic chip_select_second_i,
	input wire logic chip_select_third_n_i,
	input wire logic burst_order_select_n_i,
	input wire logic flow_through_select_n_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic [DATA_W-1:0] data_oe_o,
	output logic sleep_active_o,
	output logic wr_queue_ready_o
);
	localparam int unsigned DEPTH_WORDS = 1 << A_W;
	logic [1:0] rst_sync_ff;
	wire rst_n = rst_sync_ff[1];
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) rst_sync_ff <= '0;
		else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	// async pins pass two flops, so oe and sleep act two cycles late: the price of flop-driven outputs
	logic [1:0] oe_sync_ff;
	logic [1:0] zz_sync_ff;
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			oe_sync_ff <= '0;
			zz_sync_ff <= '0;
		end else begin
			oe_sync_ff <= {oe_sync_ff[0], ~output_enable_n_i};
			zz_sync_ff <= {zz_sync_ff[0], sleep_request_i};
		end
	end
	wire oe_on = oe_sync_ff[1];
	wire asleep = zz_sync_ff[1];

	function automatic logic [BURST_W-1:0] burst_next(input logic [BURST_W-1:0] base,
		input logic [BURST_W-1:0] cnt, input logic linear);
		burst_next = linear ? BURST_W'(base + cnt) : (base ^ cnt);
	endfunction : burst_next

	wire run = !clock_gate_n_i && !asleep;
	wire selected = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
	wire pipe_mode = flow_through_select_n_i;
	wire linear = !burst_order_select_n_i;

	logic [A_W-1:0] base_ff;
	logic [BURST_W-1:0] cnt_ff;
	logic last_wr_ff;
	logic active_ff;
	logic [LANES-1:0] last_be_ff;

	wire load = run && selected && !advance_load_i;
	wire advance_load = run && advance_load_i && active_ff;
	wire [BURST_W-1:0] nxt_cnt = load ? CNT_ZERO : BURST_W'(cnt_ff + CNT_STEP);
	wire [A_W-1:0] cmd_addr = load ? addr_i :
		{base_ff[A_W-1:BURST_W], burst_next(base_ff[BURST_W-1:0], nxt_cnt, linear)};
	wire cmd_wr = load ? !write_n_i : last_wr_ff;
	wire [LANES-1:0] cmd_be = load ? ~byte_lane_write_n_i : last_be_ff;
	wire cmd_valid = load || advance_load;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			base_ff <= '0;
			cnt_ff <= CNT_ZERO;
			last_wr_ff <= 1'b0;
			active_ff <= 1'b0;
			last_be_ff <= '0;
		end else if (run) begin
			active_ff <= load || (advance_load && active_ff) || (!selected ? 1'b0 : active_ff && advance_load_i);
			if (load) begin
				base_ff <= addr_i;
				last_wr_ff <= !write_n_i;
				last_be_ff <= ~byte_lane_write_n_i;
			end
			if (cmd_valid) cnt_ff <= nxt_cnt;
		end
	end

	// write command stages: address/lanes delayed until their data arrives
	logic [1:0] wv_ff;
	logic [A_W-1:0] wa_ff [2];
	logic [LANES-1:0] wb_ff [2];
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			wv_ff <= PIPE_STAGES_ZERO;
			wa_ff[0] <= '0;
			wa_ff[1] <= '0;
			wb_ff[0] <= '0;
			wb_ff[1] <= '0;
		end else if (run) begin
			wv_ff <= {wv_ff[0], cmd_valid && cmd_wr};
			wa_ff[0] <= cmd_addr;
			wa_ff[1] <= wa_ff[0];
			wb_ff[0] <= cmd_be;
			wb_ff[1] <= wb_ff[0];
		end
	end
	// pipelined: data at the third edge (two stages); flow-through: second edge (one)
	wire wr_due = pipe_mode ? wv_ff[1] : wv_ff[0];
	wire [A_W-1:0] wr_addr = pipe_mode ? wa_ff[1] : wa_ff[0];
	wire [LANES-1:0] wr_be = pipe_mode ? wb_ff[1] : wb_ff[0];

	// write data is queued so the core array update is decoupled from pin timing
	logic [DATA_W+A_W+LANES-1:0] q_out;
	logic q_valid;
	logic q_in_ready;
	plsram_fifo #(.WIDTH(DATA_W + A_W + LANES), .DEPTH(FIFO_DEPTH)) u_wq (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n),
		.in_data_i({wr_be, wr_addr, data_i}),
		.in_valid_i(run && wr_due),
		.in_ready_o(q_in_ready),
		.out_data_o(q_out),
		.out_valid_o(q_valid),
		.out_ready_i(run)
	);

	wire [DATA_W-1:0] q_data = q_out[DATA_W-1:0];
	wire [A_W-1:0] q_addr = q_out[DATA_W +: A_W];
	wire [LANES-1:0] q_be = q_out[DATA_W+A_W +: LANES];
	wire [DATA_W-1:0] rd_word;
	// one array per lane keeps every storage flop written from a single process
	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++) begin : g_lane
			logic [LANE_W-1:0] lane_mem_ff [DEPTH_WORDS];
			always_ff @(posedge clk_sys_i) begin
				if (run && q_valid && q_be[gl]) lane_mem_ff[q_addr] <= q_data[gl*LANE_W +: LANE_W];
			end
			assign rd_word[gl*LANE_W +: LANE_W] = lane_mem_ff[cmd_addr];
		end
	endgenerate

	// read path: no bypass of queued writes, so a read must trail a write to its word by four cycles pipelined, three flow-through
	wire rd_cmd = cmd_valid && !cmd_wr;
	logic [DATA_W-1:0] flow_ff;
	logic flow_v_ff;
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			flow_ff <= '0;
			flow_v_ff <= 1'b0;
		end else if (run) begin
			flow_ff <= rd_word;
			flow_v_ff <= rd_cmd;
		end
	end

	logic [DATA_W-1:0] dout_ff;
	logic [DATA_W-1:0] doe_ff;
	logic sleep_ff;
	logic rdy_ff;
	// flow-through drives the word read at the command edge, pipelined the word held one cycle;
	// a gated cycle keeps the last drive decision, but oe and sleep still switch it off
	wire drive = (run ? (pipe_mode ? flow_v_ff : rd_cmd) : doe_ff[0]) && oe_on && !asleep;
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			dout_ff <= '0;
			doe_ff <= '0;
			sleep_ff <= 1'b0;
			rdy_ff <= 1'b0;
		end else begin
			if (run) dout_ff <= pipe_mode ? flow_ff : rd_word;
			doe_ff <= {DATA_W{drive}};
			sleep_ff <= asleep;
			rdy_ff <= q_in_ready;
		end
	end
	assign data_o = dout_ff;
	assign data_oe_o = doe_ff;
	assign sleep_active_o = sleep_ff;
	assign wr_queue_ready_o = rdy_ff;

	property p_sel_needed;
		@(posedge clk_sys_i) disable iff (!rst_n)
		(run && !selected && !advance_load_i) |=> !flow_v_ff && !wv_ff[0];
	endproperty
	a_sel_needed: assert property (p_sel_needed) else $error("unselected load started an access");
	property p_pipe_lat;
		@(posedge clk_sys_i) disable iff (!rst_n)
		(run && rd_cmd && pipe_mode ##1 run && oe_on && !asleep && pipe_mode) |=> doe_ff[0];
	endproperty
	a_pipe_lat: assert property (p_pipe_lat) else $error("pipelined read not driven");
	property p_oe_off;
		@(posedge clk_sys_i) disable iff (!rst_n) (!oe_on |=> !doe_ff[0]);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driving while output disabled");
	property p_sleep_hold;
		@(posedge clk_sys_i) disable iff (!rst_n) (asleep |=> $stable(cnt_ff) && $stable(base_ff));
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep");
	property p_gate_hold;
		@(posedge clk_sys_i) disable iff (!rst_n)
		(clock_gate_n_i |=> $stable(wv_ff) && $stable(flow_ff) && $stable(dout_ff));
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("state moved while gated");
	sequence s_wr_cmd;
		run && cmd_valid && cmd_wr && pipe_mode;
	endsequence
	property p_late_write;
		@(posedge clk_sys_i) disable iff (!rst_n) (s_wr_cmd ##1 run && pipe_mode) |=> wv_ff[1];
	endproperty
	a_late_write: assert property (p_late_write) else $error("write not two stages late");
	property p_adv_step;
		@(posedge clk_sys_i) disable iff (!rst_n) (advance_load && !load) |=> cnt_ff == BURST_W'($past(cnt_ff) + CNT_STEP);
	endproperty
	a_adv_step: assert property (p_adv_step) else $error("burst counter did not step");
	property p_flow_lat;
		@(posedge clk_sys_i) disable iff (!rst_n) (rd_cmd && !pipe_mode && oe_on && !asleep) |=> doe_ff[0];
	endproperty
	a_flow_lat: assert property (p_flow_lat) else $error("flow read not driven at once");
endmodule : plsram_core
`default_nettype wire

// ==== bench/plsram_ctl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module plsram_ctl_model
	import plsram_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic flow_n_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic adv_o,
	output logic wr_n_o,
	output logic [LANES-1:0] lane_wr_n_o,
	output logic cs_first_n_o,
	output logic cs_second_o,
	output logic cs_third_n_o,
	output logic [DATA_W-1:0] data_o
);
	logic wv0, wv1;
	logic [DATA_W-1:0] wd0, wd1;
	initial begin
		{addr_o, adv_o, lane_wr_n_o, cs_second_o, cs_third_n_o, wv0, wv1} = '0;
		{wr_n_o, cs_first_n_o} = 2'h3;
		{data_o, wd0, wd1} = '0;
	end
	// called just after a rising edge; the command is taken at the next one
	task automatic cmd(input logic wr, input logic advance_load, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be,
		input logic [DATA_W-1:0] d, input logic [2:0] off);
		addr_o <= a;
		adv_o <= advance_load;
		wr_n_o <= !wr;
		lane_wr_n_o <= be;
		cs_first_n_o <= off[0];
		cs_second_o <= !off[1];
		cs_third_n_o <= off[2];
		wv0 <= wr;
		wd0 <= d;
	endtask : cmd
	// released data lines toggle so stale data can never pass for a fresh write
	always @(posedge clk_sys_i) begin
		wv1 <= wv0;
		wd1 <= wd0;
		if (flow_n_i ? wv1 : wv0) begin
			data_o <= flow_n_i ? wd1 : wd0;
		end else begin
			data_o <= ~data_o;
		end
	end
endmodule : plsram_ctl_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench
	import plsram_pkg::*;
;
	logic clk_sys_i, rstn_i, clock_gate_n_i, flow_n, burst_n, oe_n, sleep_req, oe_exp, advance_load, wr_n;
	logic cs1_n, cs2, cs3_n, sleep_act, wq_ready, ev0;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0] be_n;
	logic [DATA_W-1:0] wdata, rdata, rd_oe, ed0;
	logic [DATA_W-1:0] ref_mem [0:63];
	logic ev_q [1:4];
	logic [DATA_W-1:0] ed_q [1:4];
	int n_errors = 0;
	int checked = 0;
	plsram_core plsram_core_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clock_gate_n_i(clock_gate_n_i),
		.addr_i(addr), .advance_load_i(advance_load), .write_n_i(wr_n), .byte_lane_write_n_i(be_n),
		.chip_select_first_n_i(cs1_n), .chip_select_second_i(cs2), .chip_select_third_n_i(cs3_n),
		.burst_order_select_n_i(burst_n), .flow_through_select_n_i(flow_n), .output_enable_n_i(oe_n),
		.sleep_request_i(sleep_req), .data_i(wdata), .data_o(rdata), .data_oe_o(rd_oe),
		.sleep_active_o(sleep_act), .wr_queue_ready_o(wq_ready));
	plsram_ctl_model plsram_ctl_model_i (.clk_sys_i(clk_sys_i), .flow_n_i(flow_n), .addr_o(addr), .adv_o(advance_load),
		.wr_n_o(wr_n), .lane_wr_n_o(be_n), .cs_first_n_o(cs1_n), .cs_second_o(cs2), .cs_third_n_o(cs3_n),
		.data_o(wdata));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] be);
		for (int i = 0; i < LANES; i++) if (!be[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
		return o;
	endfunction : merge
	function automatic logic [ADDR_W-1:0] bnext(input logic [ADDR_W-1:0] a, input logic [1:0] k);
		logic [1:0] s;
		s = a[1:0];
		return {a[ADDR_W-1:2], burst_n ? (s ^ k) : (s + k)};
	endfunction : bnext
	function automatic logic [DATA_W-1:0] rnd();
		logic [95:0] t;
		t = {$urandom(), $urandom(), $urandom()};
		return t[DATA_W-1:0];
	endfunction : rnd
	task automatic cmp72(input string name, input logic [DATA_W-1:0] e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask : cmp72
	task automatic cmp1(input string name, input logic e, g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", name, e, g);
		end
	endtask : cmp1
	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	// the reference array only follows commands that the device should really take
	task automatic op(input logic wr, advance_load, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be,
		input logic [DATA_W-1:0] d, input logic [2:0] off, input logic take);
		@(posedge clk_sys_i);
		if (take && wr && off == 3'h0) ref_mem[a] = merge(ref_mem[a], d, be);
		ev0 <= take && !wr && off == 3'h0 && oe_exp;
		ed0 <= ref_mem[a];
		plsram_ctl_model_i.cmd(wr, advance_load, a, be, d, off);
	endtask : op
	task automatic gap(input int n);
		repeat (n) op(1'b0, 1'b0, '0, '1, '0, 3'h1, 1'b0);
	endtask : gap
	always @(posedge clk_sys_i) begin
		ev_q[1] <= ev0;
		ed_q[1] <= ed0;
		for (int k = 2; k <= 4; k++) begin
			ev_q[k] <= ev_q[k-1];
			ed_q[k] <= ed_q[k-1];
		end
	end
	always @(negedge clk_sys_i) begin
		if (ev_q[flow_n ? 2 : 1] === 1'b1) cmp72("read data", ed_q[flow_n ? 2 : 1], rdata);
		cmp72("drive enable", {DATA_W{ev_q[flow_n ? 2 : 1] === 1'b1}}, rd_oe);
	end
	task automatic run_mode(input logic ft);
		logic [ADDR_W-1:0] a;
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		flow_n <= !ft;
		burst_n <= ft;
		repeat (5) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		gap(3);
		for (int i = 0; i < 64; i++) op(1'b1, 1'b0, ADDR_W'(i), '0, rnd(), 3'h0, 1'b1);
		gap(6);
		@(negedge clk_sys_i) cmp1("queue ready", 1'b1, wq_ready);
		for (int i = 0; i < 16; i++) begin
			op(1'b0, 1'b0, ADDR_W'($urandom_range(31, 0)), '1, '0, 3'h0, 1'b1);
			op(1'b1, 1'b0, ADDR_W'($urandom_range(63, 32)), LANES'($urandom()), rnd(), 3'h0, 1'b1);
		end
		gap(6);
		for (int i = 0; i < 64; i += 4) begin
			a = ADDR_W'(i + $urandom_range(3, 0));
			for (int k = 0; k < 4; k++) op(1'b0, k != 0, bnext(a, k[1:0]), '1, '0, 3'h0, 1'b1);
		end
		gap(6);
		$display("test mixed traffic and bursts done");
		for (int b = 0; b < 3; b++) op(1'b1, 1'b0, 6'h05, '0, rnd(), 3'h1 << b, 1'b1);
		op(1'b1, 1'b0, 6'h05, '1, rnd(), 3'h0, 1'b1);
		op(1'b1, 1'b0, 6'h05, '0, rnd(), 3'h0, 1'b0);
		clock_gate_n_i <= 1'b1;
		gap(1);
		clock_gate_n_i <= 1'b0;
		gap(2);
		sleep_req <= 1'b1;
		gap(4);
		@(negedge clk_sys_i) cmp1("sleep state", 1'b1, sleep_act);
		op(1'b1, 1'b0, 6'h05, '0, rnd(), 3'h0, 1'b0);
		gap(1);
		sleep_req <= 1'b0;
		gap(4);
		@(negedge clk_sys_i) cmp1("sleep state", 1'b0, sleep_act);
		gap(1);
		oe_n <= 1'b1;
		oe_exp = 1'b0;
		gap(4);
		op(1'b0, 1'b0, 6'h05, '1, '0, 3'h0, 1'b1);
		gap(4);
		oe_n <= 1'b0;
		oe_exp = 1'b1;
		gap(4);
		op(1'b0, 1'b0, 6'h05, '1, '0, 3'h0, 1'b1);
		gap(6);
		$display("test corner cases done");
	endtask : run_mode
	initial begin
		{rstn_i, clock_gate_n_i, burst_n, oe_n, sleep_req, ev0} = '0;
		{flow_n, oe_exp} = 2'h3;
		ed0 = '0;
		for (int k = 1; k <= 4; k++) ev_q[k] = 1'b0;
		void'($urandom(32'h63f0c00e));
		run_mode(1'b0);
		run_mode(1'b1);
		final_report();
	end
	initial begin
		#(40 * 5000);
		n_errors++;
		$display("ERROR watchdog expected done seen hang");
		final_report();
	end
endmodule : testbench
`default_nettype wire
